// *** design/cmp_ctl_cfg.svh ***
// Constants for the comparator control block: offsets, bit positions, resets.
// Assumes byte-wide peripheral accesses on a 16-bit byte address.
`ifndef CMP_CTL_CFG_SVH
`define CMP_CTL_CFG_SVH
`define CMP_ADDR_CTL_ONE 16'h0059
`define CMP_ADDR_CTL_TWO 16'h005a
`define CMP_ADDR_BUF_OFF 16'h005b
`define CMP_RST_CTL_ONE 8'h00
`define CMP_RST_CTL_TWO 8'h00
`define CMP_RST_BUF_OFF 8'h00
`define CMP_B1_IRQ_FLAG 0
`define CMP_B1_IRQ_EN 1
`define CMP_B1_EDGE_SEL 2
`define CMP_B1_POWER_ON 3
`define CMP_B1_REF_LO 4
`define CMP_B1_REF_HI 5
`define CMP_B1_REF_PATH 6
`define CMP_B1_SWAP 7
`define CMP_B2_RESULT 0
`define CMP_B2_FILTER 1
`define CMP_B2_PIN_FIRST 2
`define CMP_B2_PIN_SECOND 3
`define CMP_FILTER_TAPS 3
`endif

// *** design/cmp_ctl_pkg.sv ***
// Types shared by the comparator control block.
// Assumes cmp_ctl_cfg.svh is on the include path.
package cmp_ctl_pkg;
    typedef enum logic [1:0] {
        REF_OFF = 2'b00,
        REF_QUARTER = 2'b01,
        REF_HALF = 2'b10,
        REF_DIODE = 2'b11
    } ref_level_t;
endpackage : cmp_ctl_pkg

// *** design/result_filter_if.sv ***
// Interface carrying the raw and conditioned comparator result.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface result_filter_if;
    logic raw_level;
    logic filter_sel;
    logic result_level;
    modport filt (input raw_level, input filter_sel, output result_level);
    modport user (output raw_level, output filter_sel, input result_level);
endinterface : result_filter_if

// *** design/result_filter.sv ***
// Synchroniser and optional all-taps-agree filter for the comparator output.
// Assumes the analog output is asynchronous to i_clk.
`timescale 1ns/1ns
module result_filter #(
    parameter int TAPS = 3
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Result path.
    result_filter_if.filt rf
);
    logic sync1_ff;
    logic sync2_ff;
    logic [TAPS-1:0] hist_ff;
    logic out_ff;

    // Two flops bring the analog level into the clock domain.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= rf.raw_level;
            sync2_ff <= sync1_ff;
        end
    end

    // The filter only moves when all taps agree, trading latency for noise.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            hist_ff <= '0;
            out_ff <= 1'b0;
        end else begin
            hist_ff <= {hist_ff[TAPS-2:0], sync2_ff};
            if (!rf.filter_sel) begin
                out_ff <= sync2_ff;
            end else if (&hist_ff) begin
                out_ff <= 1'b1;
            end else if (~|hist_ff) begin
                out_ff <= 1'b0;
            end
        end
    end

    assign rf.result_level = out_ff;

    // While the taps disagree a filtered output must not move.
    filter_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        rf.filter_sel && |hist_ff && !(&hist_ff) |=> $stable(out_ff))
        else $error("filter passed a short pulse");
endmodule : result_filter

// *** design/analog_comparator_control.sv ***
// Control and status registers of the analog comparator, byte accessed.
// Assumes a synchronous peripheral byte bus and an asynchronous analog core.
//
// Operation
// - Bit 0 of control two shows result; bit 1 selects filtering.
// - Bit 2 of control two connects the first shared pin.
// - Bit 3 of control two connects the second shared pin.
// - Control two bits 4 to 7 are plain storage with no function.
// - Flag sets on rising edge, or falling when edge select is one.
// - Bit 3 of control one powers the comparator.
// - Reference field: off, quarter, half or diode reference.
// - Bit 6 of control one routes reference to path one or two.
// - Reference is driven only when the field is nonzero.
// - Bit 7 of control one swaps the comparator inputs.
// - Eight buffer-disable bits, all cleared at reset.
// - Each set buffer-disable bit turns off that pin's input buffer.
// - The three registers decode at 059h, 05Ah and 05Bh as bytes.
`timescale 1ns/1ns
`include "cmp_ctl_cfg.svh"
module analog_comparator_control (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Byte register port.
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Analog core.
    input wire logic i_cmp_raw,
    output logic o_cmp_power_on,
    output logic [1:0] o_ref_level_sel,
    output logic o_ref_drive_en,
    output logic o_ref_path_sel,
    output logic o_input_swap,
    output logic o_input_pin_first,
    output logic o_input_pin_second,
    // Port and interrupt.
    output logic [7:0] o_port_buffer_disable,
    output logic o_cmp_irq
);
    logic [7:0] ctl_one_ff;
    logic [7:0] ctl_two_ff;
    logic [7:0] buf_off_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic prev_ff;
    logic edge_hit;
    logic wr_one;
    logic [7:0] nxt_ctl_one;
    logic ref_drive_ff;
    result_filter_if rf ();

    // Shared decode so that read and write agree on the map.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction : hit

    assign rf.raw_level = i_cmp_raw & ctl_one_ff[`CMP_B1_POWER_ON];
    assign rf.filter_sel = ctl_two_ff[`CMP_B2_FILTER];

    result_filter #(.TAPS(`CMP_FILTER_TAPS)) u_filter (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .rf(rf)
    );

    // Edge of the conditioned result, polarity chosen by the edge select.
    assign edge_hit = ctl_one_ff[`CMP_B1_EDGE_SEL] ?
        (prev_ff & ~rf.result_level) : (~prev_ff & rf.result_level);
    assign wr_one = i_wr && hit(i_addr, `CMP_ADDR_CTL_ONE);

    // Control one; a hardware edge wins over a software clear of the flag.
    always_comb begin
        nxt_ctl_one = ctl_one_ff;
        if (wr_one) begin
            nxt_ctl_one = i_wdata;
        end
        if (edge_hit) begin
            nxt_ctl_one[`CMP_B1_IRQ_FLAG] = 1'b1;
        end
    end

    // Control one and the previous result level move together each clock.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctl_one_ff <= `CMP_RST_CTL_ONE;
            prev_ff <= 1'b0;
        end else begin
            ctl_one_ff <= nxt_ctl_one;
            prev_ff <= rf.result_level;
        end
    end

    // Reference drive has its own flop so the analog side sees no decode glitch.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ref_drive_ff <= 1'b0;
        end else begin
            ref_drive_ff <= nxt_ctl_one[`CMP_B1_REF_HI:`CMP_B1_REF_LO] !=
                cmp_ctl_pkg::REF_OFF;
        end
    end

    // Control two: result bit is read-only, the rest is storage.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctl_two_ff <= `CMP_RST_CTL_TWO;
        end else begin
            if (i_wr && hit(i_addr, `CMP_ADDR_CTL_TWO)) begin
                ctl_two_ff[7:1] <= i_wdata[7:1];
            end
            ctl_two_ff[`CMP_B2_RESULT] <= rf.result_level;
        end
    end

    // Buffer disables clear at reset so every input buffer starts active.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            buf_off_ff <= `CMP_RST_BUF_OFF;
        end else if (i_wr && hit(i_addr, `CMP_ADDR_BUF_OFF)) begin
            buf_off_ff <= i_wdata;
        end
    end

    // Registered read data; unmapped addresses read as zero.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_ff <= 8'h00;
        end else if (i_rd) begin
            if (hit(i_addr, `CMP_ADDR_CTL_ONE)) begin
                rdata_ff <= ctl_one_ff;
            end else if (hit(i_addr, `CMP_ADDR_CTL_TWO)) begin
                rdata_ff <= ctl_two_ff;
            end else if (hit(i_addr, `CMP_ADDR_BUF_OFF)) begin
                rdata_ff <= buf_off_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // Interrupt request follows flag and enable of the next state.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_ctl_one[`CMP_B1_IRQ_FLAG] &
                nxt_ctl_one[`CMP_B1_IRQ_EN];
        end
    end

    // Analog controls are taken straight from the register flops, except reference drive, which comes from its own flop.
    assign o_rdata = rdata_ff;
    assign o_cmp_power_on = ctl_one_ff[`CMP_B1_POWER_ON];
    assign o_ref_level_sel = ctl_one_ff[`CMP_B1_REF_HI:`CMP_B1_REF_LO];
    assign o_ref_drive_en = ref_drive_ff;
    assign o_ref_path_sel = ctl_one_ff[`CMP_B1_REF_PATH];
    assign o_input_swap = ctl_one_ff[`CMP_B1_SWAP];
    assign o_input_pin_first = ctl_two_ff[`CMP_B2_PIN_FIRST];
    assign o_input_pin_second = ctl_two_ff[`CMP_B2_PIN_SECOND];
    assign o_port_buffer_disable = buf_off_ff;
    assign o_cmp_irq = irq_ff;

    // Checks next to the logic they guard.
    edge_sets_flag_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        edge_hit |=> ctl_one_ff[`CMP_B1_IRQ_FLAG])
        else $error("edge did not set flag");
    rise_sets_flag_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $rose(rf.result_level) && !ctl_one_ff[`CMP_B1_EDGE_SEL] |=>
        ctl_one_ff[`CMP_B1_IRQ_FLAG])
        else $error("rising edge did not set flag");
    fall_sets_flag_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $fell(rf.result_level) && ctl_one_ff[`CMP_B1_EDGE_SEL] |=>
        ctl_one_ff[`CMP_B1_IRQ_FLAG])
        else $error("falling edge did not set flag");
    flag_quiet_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        !ctl_one_ff[`CMP_B1_IRQ_FLAG] && !wr_one && $stable(rf.result_level)
        |=> !ctl_one_ff[`CMP_B1_IRQ_FLAG])
        else $error("flag set without an edge");
    flag_holds_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        ctl_one_ff[`CMP_B1_IRQ_FLAG] && !wr_one |=>
        ctl_one_ff[`CMP_B1_IRQ_FLAG])
        else $error("flag dropped without clear");
    irq_match_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        o_cmp_irq == (ctl_one_ff[`CMP_B1_IRQ_FLAG] &&
        ctl_one_ff[`CMP_B1_IRQ_EN]))
        else $error("irq mismatch");
    power_write_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        wr_one |=> o_cmp_power_on == $past(i_wdata[`CMP_B1_POWER_ON]))
        else $error("power control not written");
    ref_write_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        wr_one |=>
        o_ref_level_sel == $past(i_wdata[`CMP_B1_REF_HI:`CMP_B1_REF_LO]))
        else $error("reference field not written");
    path_write_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        wr_one |=> o_ref_path_sel == $past(i_wdata[`CMP_B1_REF_PATH]))
        else $error("reference path not written");
    ref_drive_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        o_ref_drive_en == (o_ref_level_sel != 2'b00))
        else $error("reference drive wrong");
    swap_write_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        wr_one |=> o_input_swap == $past(i_wdata[`CMP_B1_SWAP]))
        else $error("input swap not written");
    result_bit_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        ##1 ctl_two_ff[`CMP_B2_RESULT] == $past(rf.result_level))
        else $error("result bit stale");
    store_two_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == `CMP_ADDR_CTL_TWO |=>
        ctl_two_ff[7:4] == $past(i_wdata[7:4]))
        else $error("storage bits not written");
    pin_first_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == `CMP_ADDR_CTL_TWO |=>
        o_input_pin_first == $past(i_wdata[`CMP_B2_PIN_FIRST]))
        else $error("first pin connect wrong");
    pin_second_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == `CMP_ADDR_CTL_TWO |=>
        o_input_pin_second == $past(i_wdata[`CMP_B2_PIN_SECOND]))
        else $error("second pin connect wrong");
    buf_write_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == `CMP_ADDR_BUF_OFF |=>
        o_port_buffer_disable == $past(i_wdata))
        else $error("buffer disable not written");
    buf_reset_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> o_port_buffer_disable == `CMP_RST_BUF_OFF)
        else $error("buffer disable not cleared by reset");
    read_one_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `CMP_ADDR_CTL_ONE |=>
        o_rdata == $past(ctl_one_ff))
        else $error("read of control one wrong");
endmodule : analog_comparator_control

// *** bench/cmp_core_model.sv ***
// Behavioural model of the analog comparator core.
// Assumes the bench sets the sign of the comparison through i_level.
`timescale 1ns/1ns
module cmp_core_model (
    // Control from the block.
    input wire logic i_power_on,
    input wire logic i_input_swap,
    // Analog comparison commanded by the bench.
    input wire logic i_level,
    // Raw comparator output.
    output logic o_raw
);
    // An unpowered core rests low; swapped inputs invert the sign.
    assign o_raw = i_power_on & (i_level ^ i_input_swap);
endmodule : cmp_core_model

// *** bench/analog_comparator_control_tb_top.sv ***
// Self-checking bench for the comparator control registers.
// Assumes the design and cmp_core_model; inputs change on falling edges.
`timescale 1ns/1ns
`include "cmp_ctl_cfg.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
    n_mismatch++; $display("Error %s exp %h got %h", nm, e, s); end end
module analog_comparator_control_tb_top;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic level = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic raw, pwr, drv, path, swp, pin1, pin2, irq;
    logic [7:0] rdata, bufoff, v, got;
    logic [1:0] refs;
    int n_mismatch = 0;
    int n_compared = 0;

    analog_comparator_control dut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .o_rdata(rdata), .i_cmp_raw(raw), .o_cmp_power_on(pwr),
        .o_ref_level_sel(refs), .o_ref_drive_en(drv),
        .o_ref_path_sel(path), .o_input_swap(swp),
        .o_input_pin_first(pin1), .o_input_pin_second(pin2),
        .o_port_buffer_disable(bufoff), .o_cmp_irq(irq));
    cmp_core_model core (.i_power_on(pwr), .i_input_swap(swp),
        .i_level(level), .o_raw(raw));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    // One-cycle write strobe, launched and dropped on falling edges.
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clk);
        wr = 1'b0;
    endtask : wr_reg

    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        rd = 1'b1;
        @(negedge i_clk);
        rd = 1'b0;
        d = rdata;
    endtask : rd_reg

    // Bounded wait, since the synchroniser and filter add a few cycles.
    task automatic wait_irq(input logic e);
        for (int i = 0; i < 40 && irq !== e; i++) begin
            @(negedge i_clk);
        end
        `CHK("irq", e, irq)
    endtask : wait_irq

    // The reference is driven for every field code except off.
    function automatic logic exp_drv(input logic [7:0] c);
        return c[5:4] != cmp_ctl_pkg::REF_OFF;
    endfunction : exp_drv

    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog, far beyond the few hundred cycles the tests need.
    initial begin
        #100us;
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence: reset values, random fields, then edge handling.
    initial begin
        void'($urandom(32'hdb7e));
        repeat (10) @(negedge i_clk);
        i_resetn = 1'b1;
        rd_reg(`CMP_ADDR_CTL_ONE, got);
        `CHK("ctl_one", 8'h00, got)
        rd_reg(`CMP_ADDR_BUF_OFF, got);
        `CHK("buf_off", 8'h00, got)
        `CHK("buf_out", 8'h00, bufoff)
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 8'hfe : 8'($urandom) & 8'hfe;
            // Swap with power on would fake a comparator edge here.
            if (v[7]) v[3] = 1'b0;
            wr_reg(`CMP_ADDR_CTL_ONE, v);
            `CHK("power_on", v[3], pwr)
            `CHK("ref_sel", v[5:4], refs)
            `CHK("ref_drive", exp_drv(v), drv)
            `CHK("ref_path", v[6], path)
            `CHK("swap", v[7], swp)
            `CHK("no_irq", 1'b0, irq)
            rd_reg(`CMP_ADDR_CTL_ONE, got);
            `CHK("ctl_one_rd", v, got)
            wr_reg(`CMP_ADDR_CTL_TWO, v | 8'h01);
            `CHK("pin_first", v[2], pin1)
            `CHK("pin_second", v[3], pin2)
            rd_reg(`CMP_ADDR_CTL_TWO, got);
            `CHK("ctl_two_rd", v, got)
            wr_reg(`CMP_ADDR_BUF_OFF, ~v);
            `CHK("buf_out", ~v, bufoff)
            rd_reg(`CMP_ADDR_BUF_OFF, got);
            `CHK("buf_rd", ~v, got)
        end
        wr_reg(16'h005c, 8'hff);
        rd_reg(16'h005c, got);
        `CHK("unmapped", 8'h00, got)
        wr_reg(`CMP_ADDR_CTL_TWO, 8'h02);
        wr_reg(`CMP_ADDR_CTL_ONE, 8'h0a);
        level = 1'b1;
        wait_irq(1'b1);
        rd_reg(`CMP_ADDR_CTL_TWO, got);
        `CHK("result", 8'h03, got)
        rd_reg(`CMP_ADDR_CTL_ONE, got);
        `CHK("flag_held", 8'h0b, got)
        wr_reg(`CMP_ADDR_CTL_ONE, 8'h0e);
        `CHK("irq_clr", 1'b0, irq)
        level = 1'b0;
        wait_irq(1'b1);
        wr_reg(`CMP_ADDR_CTL_ONE, 8'h0c);
        wr_reg(`CMP_ADDR_CTL_TWO, 8'h00);
        level = 1'b1;
        repeat (20) @(negedge i_clk);
        rd_reg(`CMP_ADDR_CTL_ONE, got);
        `CHK("no_rise_flag", 8'h0c, got)
        rd_reg(`CMP_ADDR_CTL_TWO, got);
        `CHK("result_raw", 8'h01, got)
        // A one-cycle dip must be swallowed once filtering is on.
        wr_reg(`CMP_ADDR_CTL_TWO, 8'h02);
        level = 1'b0;
        @(negedge i_clk);
        level = 1'b1;
        repeat (10) @(negedge i_clk);
        rd_reg(`CMP_ADDR_CTL_ONE, got);
        `CHK("glitch_blocked", 8'h0c, got)
        rd_reg(`CMP_ADDR_CTL_TWO, got);
        `CHK("glitch_result", 8'h03, got)
        report_and_stop();
    end
endmodule : analog_comparator_control_tb_top
